/* File: logic/stack_unit_defines.svh */
// constants for the stack pointer unit
`ifndef STACK_UNIT_DEFINES_SVH
`define STACK_UNIT_DEFINES_SVH
`define SP_RESET_VALUE 16'h1000
`define SP_STEP 16'h0002
`define SP_ALIGN_MASK 16'hFFFE
`define PC_LOW_MSB 15
`define PC_HIGH_MSB 22
`define PC_HIGH_LSB 16
`define PC_HIGH_WIDTH 7
`define STATUS_LOW_MSB 7
`define IPL_MSB 7
`define IPL_LSB 5
`endif

/* File: logic/stack_unit_pkg.sv */
// types shared by the stack pointer unit
package stack_unit_pkg;
	typedef enum logic [2:0] {
		op_none,
		op_push_word,
		op_pop_word,
		op_call,
		op_exception,
		op_return
	} stack_op_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_type;
endpackage

/* File: logic/stack_ptr_reg.sv */
// stack pointer register with forced word alignment
`timescale 1ns/1ps
`include "stack_unit_defines.svh"
module stack_ptr_reg (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [15:0] i_value,
	output logic [15:0] o_value
);
	logic [15:0] value;
	logic [15:0] next_value;

	// bit 0 is masked on every load, so no write can misalign the stack
	always_comb begin
		next_value = value;
		if (i_load) begin
			next_value = i_value & `SP_ALIGN_MASK;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			value <= `SP_RESET_VALUE;
		end else begin
			value <= next_value;
		end
	end

	assign o_value = value;
endmodule

/* File: logic/software_stack_pointer_unit.sv */
// stack pointer unit: pushes, pops and program counter stacking
//
// What this block does
// - pointer auto-updates on calls, exceptions, returns; writable
// - pointer bit 0 always reads zero
// - every reset loads pointer with 0x1000
// - software may relocate pointer when idle; new value used, writes during an op dropped
// - pointer addresses first free word, grows upward
// - push writes then increments; pop decrements then reads
// - pc low word first, pc 22:16 next
// - call push zero-fills upper byte of word two
// - exception push saves status low byte in word two
// - stack addresses unpaged, 0x0000 to 0xFFFF only
// - frame pointer unpaged when frame mode active
// - saved status bits 7:5 carry priority level
//
// stack frame as seen in data memory, lowest address first:
//   sp_before + 0 : pc bits 15:0 (call and exception)
//   sp_before + 2 : upper byte, one zero bit, pc bits 22:16
//   sp_after      : first free word, where the next push lands
// a plain word push uses only the second slot of that layout, so the
// sequencer enters at its second write state and skips the low pc word.
// the upper byte of the second word is zero for a call and the saved
// status low byte for an exception, with the priority level forced in
// from the live priority input so that a return restores both at once.
// the pointer never crosses into paged data space: all arithmetic stays
// inside 16 bits and simply wraps, which the user must avoid by keeping
// the stack well clear of the top of the address range.
`timescale 1ns/1ps
`include "stack_unit_defines.svh"
module software_stack_pointer_unit
	import stack_unit_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire stack_op_type i_op,
	input wire logic [15:0] i_push_data,
	input wire logic [22:0] i_pc,
	input wire logic [7:0] i_status_low_byte,
	input wire logic [2:0] i_interrupt_priority_level,
	input wire logic i_sp_write,
	input wire logic [15:0] i_sp_wdata,
	input wire logic [15:0] i_frame_pointer_reg,
	input wire logic i_frame_pointer_active,
	input wire logic i_mem_ready,
	input wire logic [15:0] i_mem_rdata,
	output mem_req_type o_mem_req,
	output logic o_extended_data_paging,
	output logic o_frame_paging_bypass,
	output logic [15:0] o_frame_addr,
	output logic o_busy,
	output logic o_done,
	output logic [15:0] o_pop_data,
	output logic [22:0] o_return_pc,
	output logic [7:0] o_restored_status,
	output logic [15:0] o_stack_pointer_reg
);
	typedef enum logic [2:0] {
		st_idle,
		st_push_one,
		st_push_two,
		st_pop_one,
		st_pop_two
	} seq_state_type;

	// sequencer group: where we are, which op runs, and the second word to write
	seq_state_type state;
	seq_state_type next_state;
	stack_op_type op;
	stack_op_type next_op;
	logic [15:0] second_word;
	logic [15:0] next_second_word;

	// result group: words read back by pops and the done pulse
	logic [15:0] high_word;
	logic [15:0] next_high_word;
	logic done;
	logic next_done;
	logic [15:0] pop_data;
	logic [15:0] next_pop_data;
	logic [22:0] return_pc;
	logic [22:0] next_return_pc;
	logic [7:0] restored_status;
	logic [7:0] next_restored_status;

	// pointer load request towards the aligned pointer register
	logic sp_load;
	logic [15:0] sp_load_value;
	logic [15:0] stack_pointer_reg;

	// pointer steps by one 16-bit word; the sum wraps inside 16 bits
	function automatic logic [15:0] step_up(input logic [15:0] sp);
		step_up = sp + `SP_STEP;
	endfunction

	function automatic logic [15:0] step_down(input logic [15:0] sp);
		step_down = sp - `SP_STEP;
	endfunction

	// word two of a pc push: call zero-fills, exception saves status low byte
	function automatic logic [15:0] pc_high_word(input logic [22:0] pc,
			input logic with_status, input logic [7:0] status_low_byte, input logic [2:0] interrupt_priority_level);
		logic [7:0] upper;
		upper = 8'h00;
		if (with_status) begin
			upper = status_low_byte;
			upper[`IPL_MSB:`IPL_LSB] = interrupt_priority_level;
		end
		pc_high_word = {upper, 1'b0, pc[`PC_HIGH_MSB:`PC_HIGH_LSB]};
	endfunction

	// the pointer lives in its own register so that alignment is enforced in
	// one place for both software writes and automatic steps; the sequencer
	// only ever asks for a load and never writes the pointer directly
	stack_ptr_reg u_sp (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_load(sp_load),
		.i_value(sp_load_value),
		.o_value(stack_pointer_reg)
	);

	// sequencer: one word per memory handshake, pointer moves on acceptance
	always_comb begin
		next_state = state;
		next_op = op;
		next_second_word = second_word;
		sp_load = 1'b0;
		sp_load_value = stack_pointer_reg;
		o_mem_req = '0;
		case (state)
			st_idle: begin
				// a software write takes the pointer like any working register
				if (i_sp_write) begin
					sp_load = 1'b1;
					sp_load_value = i_sp_wdata;
				end else begin
					next_op = i_op;
					case (i_op)
						op_push_word: begin
							next_state = st_push_two;
							next_second_word = i_push_data;
						end
						op_call, op_exception: begin
							next_state = st_push_one;
							next_second_word = pc_high_word(i_pc, i_op == op_exception,
								i_status_low_byte, i_interrupt_priority_level);
						end
						op_pop_word, op_return: begin
							next_state = (i_op == op_return) ? st_pop_one : st_pop_two;
						end
						default: begin
							next_state = st_idle;
						end
					endcase
				end
			end
			st_push_one: begin
				// low pc word goes to the first free word
				o_mem_req = '{1'b1, 1'b1, stack_pointer_reg, i_pc[`PC_LOW_MSB:0]};
				if (i_mem_ready) begin
					sp_load = 1'b1;
					sp_load_value = step_up(stack_pointer_reg);
					next_state = st_push_two;
				end
			end
			st_push_two: begin
				// write at the pointer, then post-increment
				o_mem_req = '{1'b1, 1'b1, stack_pointer_reg, second_word};
				if (i_mem_ready) begin
					sp_load = 1'b1;
					sp_load_value = step_up(stack_pointer_reg);
					next_state = st_idle;
				end
			end
			st_pop_one: begin
				// return pops the high word first, the pre-decremented address
				o_mem_req = '{1'b1, 1'b0, step_down(stack_pointer_reg), 16'h0000};
				if (i_mem_ready) begin
					sp_load = 1'b1;
					sp_load_value = step_down(stack_pointer_reg);
					next_state = st_pop_two;
				end
			end
			st_pop_two: begin
				o_mem_req = '{1'b1, 1'b0, step_down(stack_pointer_reg), 16'h0000};
				if (i_mem_ready) begin
					sp_load = 1'b1;
					sp_load_value = step_down(stack_pointer_reg);
					next_state = st_idle;
				end
			end
			default: begin
				next_state = st_idle;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= st_idle;
			op <= op_none;
			second_word <= 16'h0000;
		end else begin
			state <= next_state;
			op <= next_op;
			second_word <= next_second_word;
		end
	end

	// pop results: taken on the accepting edge and held until the next pop;
	// kept apart from the sequencer so the pointer path stays short
	always_comb begin
		next_high_word = high_word;
		next_done = 1'b0;
		next_pop_data = pop_data;
		next_return_pc = return_pc;
		next_restored_status = restored_status;
		case (state)
			st_push_two: begin
				// the last pushed word ends the op
				if (i_mem_ready) begin
					next_done = 1'b1;
				end
			end
			st_pop_one: begin
				// a return reads its high word first
				if (i_mem_ready) begin
					next_high_word = i_mem_rdata;
				end
			end
			st_pop_two: begin
				if (i_mem_ready) begin
					next_done = 1'b1;
					next_pop_data = i_mem_rdata;
					// only a return rebuilds pc and status from the two words
					if (op == op_return) begin
						next_return_pc = {high_word[`PC_HIGH_WIDTH-1:0], i_mem_rdata};
						next_restored_status = high_word[15:8];
					end
				end
			end
			default: begin
				next_done = 1'b0;
			end
		endcase
	end

	// result registers; cleared on reset so no stale pop shows after it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			high_word <= 16'h0000;
			done <= 1'b0;
			pop_data <= 16'h0000;
			return_pc <= 23'h000000;
			restored_status <= 8'h00;
		end else begin
			high_word <= next_high_word;
			done <= next_done;
			pop_data <= next_pop_data;
			return_pc <= next_return_pc;
			restored_status <= next_restored_status;
		end
	end

	// frame pointer in frame mode is a stack address too, so it bypasses
	// paging; the address itself passes unmodified in its 16 bits
	always_comb begin
		o_frame_paging_bypass = 1'b0;
		o_frame_addr = i_frame_pointer_reg;
		if (i_frame_pointer_active) begin
			o_frame_paging_bypass = 1'b1;
		end
	end

	// stack addresses never carry a page; 16-bit range only
	assign o_extended_data_paging = 1'b0;
	assign o_busy = (state != st_idle);
	assign o_done = done;
	assign o_pop_data = pop_data;
	assign o_return_pc = return_pc;
	assign o_restored_status = restored_status;
	assign o_stack_pointer_reg = stack_pointer_reg;
endmodule

/* File: testbench/stack_unit_sva.sv */
// port checker for the stack pointer unit
`timescale 1ns/1ps
module stack_unit_sva
	import stack_unit_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire stack_op_type i_op,
	input wire logic i_sp_write,
	input wire mem_req_type o_mem_req,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic [15:0] o_stack_pointer_reg
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// an op is taken only when idle and no software write competes
	wire logic go = !o_busy && !i_sp_write;
	property p_al; o_stack_pointer_reg[0] == 1'b0; endproperty
	a_al: assert property (p_al) else $error("sp odd");
	property p_rs; $fell(i_rst) |-> o_stack_pointer_reg == 16'h1000; endproperty
	a_rs: assert property (p_rs) else $error("sp reset");
	property p_pu;
		go && i_op == op_push_word |=> o_mem_req.valid && o_mem_req.write
			&& o_mem_req.addr == o_stack_pointer_reg;
	endproperty
	a_pu: assert property (p_pu) else $error("push addr");
	property p_po;
		go && i_op == op_pop_word |=> o_mem_req.valid && !o_mem_req.write
			&& o_mem_req.addr == o_stack_pointer_reg - 16'h0002;
	endproperty
	a_po: assert property (p_po) else $error("pop addr");
	// the last word written ends just below the new pointer
	property p_ws;
		o_done && $past(o_mem_req.write) |-> o_stack_pointer_reg == $past(o_mem_req.addr) + 16'h0002;
	endproperty
	a_ws: assert property (p_ws) else $error("push step");
	property p_rd;
		o_done && !$past(o_mem_req.write) |-> o_stack_pointer_reg == $past(o_mem_req.addr);
	endproperty
	a_rd: assert property (p_rd) else $error("pop step");
	property p_bz; go && i_op != op_none |=> o_busy && !o_done; endproperty
	a_bz: assert property (p_bz) else $error("not busy");
	property p_dn; o_done |=> !o_done; endproperty
	a_dn: assert property (p_dn) else $error("done long");
	c_ex: cover property (go && i_op == op_exception);
	c_rt: cover property (go && i_op == op_return);
	c_rs: cover property ($fell(i_rst));
endmodule
bind software_stack_pointer_unit stack_unit_sva stack_unit_sva_i (.i_clk, .i_rst, .i_op,
	.i_sp_write, .o_mem_req, .o_busy, .o_done, .o_stack_pointer_reg);

/* File: testbench/stack_mem_model.sv */
// data memory model holding the stack
`timescale 1ns/1ps
module stack_mem_model
	import stack_unit_pkg::*;
(
	input wire logic i_clk,
	input wire mem_req_type i_req,
	input wire logic i_slow,
	output logic o_ready,
	output logic [15:0] o_rdata
);
	logic [15:0] mem [0:32767];
	logic [15:0] last = 16'h0000;
	logic ok = 1'b1;
	// slow mode adds random wait states; the unit must hold its request meanwhile
	always @(negedge i_clk) ok <= !i_slow || $urandom_range(2) == 0;
	assign o_ready = i_req.valid && ok;
	// outside a served read the data lines toggle so stale data never looks valid
	assign o_rdata = (o_ready && !i_req.write) ? mem[i_req.addr[15:1]] : ~last;
	always @(posedge i_clk) begin
		last <= o_rdata;
		if (o_ready && i_req.write) mem[i_req.addr[15:1]] <= i_req.wdata;
	end
endmodule

/* File: testbench/tb_software_stack_pointer_unit.sv */
// self-checking bench for the stack pointer unit
`timescale 1ns/1ps
module tb_software_stack_pointer_unit;
	import stack_unit_pkg::*;
	logic i_clk = 1'b0, i_rst = 1'b1, i_sp_write = 1'b0, i_frame_pointer_active = 1'b0, slow = 1'b0;
	stack_op_type i_op = op_none, op;
	logic [15:0] i_push_data = 16'h0000, i_sp_wdata = 16'h0000, i_frame_pointer_reg = 16'h0000;
	logic [22:0] i_pc = 23'h000000, o_return_pc, rpc_m;
	logic [7:0] i_status_low_byte = 8'h00, o_restored_status, rst_m;
	logic [2:0] i_interrupt_priority_level = 3'h0;
	logic i_mem_ready, o_extended_data_paging, o_frame_paging_bypass, o_busy, o_done;
	logic [15:0] i_mem_rdata, o_frame_addr, o_pop_data, o_stack_pointer_reg, base, pop_m, hi;
	mem_req_type o_mem_req;
	logic [63:0] notes[$];
	logic [15:0] stk[$];
	int n_fail = 0, cmp_count = 0;
	wire logic [63:0] seen = {o_stack_pointer_reg, o_pop_data, o_return_pc, o_restored_status,
		o_extended_data_paging};
	always #2 i_clk = ~i_clk;
	software_stack_pointer_unit software_stack_pointer_unit_i (.i_clk, .i_rst, .i_op,
		.i_push_data, .i_pc, .i_status_low_byte, .i_interrupt_priority_level, .i_sp_write,
		.i_sp_wdata, .i_frame_pointer_reg, .i_frame_pointer_active, .i_mem_ready, .i_mem_rdata,
		.o_mem_req, .o_extended_data_paging, .o_frame_paging_bypass, .o_frame_addr, .o_busy,
		.o_done, .o_pop_data, .o_return_pc, .o_restored_status, .o_stack_pointer_reg);
	stack_mem_model stack_mem_model_i (.i_clk, .i_req(o_mem_req), .i_slow(slow),
		.o_ready(i_mem_ready), .o_rdata(i_mem_rdata));
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic do_reset;
		i_rst = 1'b1;
		repeat (5) @(negedge i_clk);
		i_rst = 1'b0;
		base = 16'h1000;
		stk.delete();
		{pop_m, rpc_m, rst_m} = '0;
		check(64'(o_stack_pointer_reg), 64'h1000);
	endtask
	// the pending call must be ignored because the software write wins
	task automatic set_sp(input logic [15:0] v);
		i_sp_write = 1'b1;
		i_sp_wdata = v;
		i_op = op_call;
		@(negedge i_clk);
		{i_sp_write, i_op} = {1'b0, op_none};
		base = v & 16'hFFFE;
		stk.delete();
		check(64'(o_stack_pointer_reg), 64'(base));
	endtask
	// issue one op and note the outputs it must leave; stk mirrors the stack words
	task automatic do_op(input stack_op_type o);
		{i_op, i_push_data, i_pc} = {o, 16'($urandom), 23'($urandom)};
		{i_status_low_byte, i_interrupt_priority_level} = 11'($urandom);
		{i_frame_pointer_active, i_frame_pointer_reg} = 17'($urandom);
		case (o)
		op_push_word: stk.push_back(i_push_data);
		op_pop_word: pop_m = stk.pop_back();
		op_call, op_exception: begin
			stk.push_back(i_pc[15:0]);
			hi = {o == op_call ? 8'h00 : {i_interrupt_priority_level, i_status_low_byte[4:0]},
				1'b0, i_pc[22:16]};
			stk.push_back(hi);
		end
		default: begin
			hi = stk.pop_back();
			pop_m = stk.pop_back();
			{rpc_m, rst_m} = {hi[6:0], pop_m, hi[15:8]};
		end
		endcase
		notes.push_back({base + 16'(2 * stk.size()), pop_m, rpc_m, rst_m, 1'b0});
		@(negedge i_clk);
		i_op = op_none;
		check(64'({o_frame_paging_bypass, o_frame_addr}), 64'({i_frame_pointer_active,
			i_frame_pointer_reg}));
		repeat (50) if (o_busy === 1'b1) @(negedge i_clk);
	endtask
	// finished ops are matched against the oldest note
	always @(negedge i_clk) begin
		if (o_done === 1'b1) check(seen, notes.pop_front());
	end
	initial begin
		void'($urandom(32'hdbb4));
		do_reset();
		for (int k = 0; k < 60; k++) begin
			if (k == 30) do_reset();
			if (k % 20 == 10) set_sp(16'($urandom_range(16'hF000, 16'h2000)) | 16'h0001);
			slow = 1'($urandom);
			op = stack_op_type'($urandom_range(5, 1));
			if (op == op_return && stk.size() < 2 || op == op_pop_word && stk.size() < 1)
				op = op_call;
			do_op(op);
		end
		repeat (3) @(negedge i_clk);
		check(64'(notes.size()), 64'h0);
		stop_test();
	end
	// a hang counts as a mismatch
	initial begin
		#20us;
		n_fail++;
		stop_test();
	end
endmodule
